//--- src/aos_map.vh
// Constants for the output and sense selection block.
`ifndef AOS_MAP_VH
`define AOS_MAP_VH
`define AOS_ADDR_TERM     4'h0
`define AOS_ADDR_ESW      4'h1
`define AOS_ADDR_SENSE    4'h2
`define AOS_ADDR_BAT2SP   4'h3
`define AOS_ADDR_FLOAT    4'h4
`define AOS_ADDR_SWITCHING_HYSTERESIS     4'h5
`define AOS_ADDR_STATUS   4'h6
`define AOS_ADDR_ESWOUT   4'h7
`define AOS_LOAD_TERMINAL_FUNCTION_SELECT_RST      4'h1
`define AOS_RELAY_OUTPUT_FUNCTION_SELECT_RST      4'h2
`define AOS_EXT_SWITCH_FUNCTION_SELECT_RST      3'h0
`define AOS_PROG_EDIT     3'h4
`define AOS_FN_DISC_ON    4'h0
`define AOS_FN_DISC_OFF   4'h1
`define AOS_FN_GEN_ON     4'h2
`define AOS_FN_GEN_OFF    4'h3
`define AOS_FN_EVT_ON     4'h4
`define AOS_FN_EVT_OFF    4'h5
`define AOS_FN_B2_ON      4'h6
`define AOS_FN_B2_OFF     4'h7
`define AOS_FN_ALM_ON     4'h8
`define AOS_FN_ALM_OFF    4'h9
`define AOS_FN_SHUNT_ON   4'hA
`define AOS_FN_SHUNT_OFF  4'hB
`define AOS_SENSE_MAIN    2'h0
`define AOS_SENSE_SECOND_BATTERY_SETPOINT    2'h1
`define AOS_SENSE_EXTERNAL_VOLTAGE_EVENT_INPUT    2'h2
`define AOS_SENSE_EQ      2'h3
`define AOS_NUM_ESW       4'hC
`define AOS_RELAY_GAP_S   30
`define AOS_CLK_HZ        100000000
`define AOS_RELAY_GAP_CYC 32'd3000000000
`define AOS_PWM_HZ        58
`define AOS_PWM_PERIOD    21'd1724137
`define AOS_TX_IDLE       2'h0
`define AOS_TX_SEND       2'h1
`endif

//--- src/aos_sel_mem.v
// Small memory holding one function selection per external switch block.
`timescale 1ns/100ps
`default_nettype none
`include "aos_map.vh"
module aos_sel_mem (
    input  wire       clk,
    input  wire       arst_n,
    input  wire       wr_en,
    input  wire [3:0] wr_addr,
    input  wire [2:0] wr_data,
    input  wire [3:0] rd_addr,
    output reg  [2:0] rd_data
);
    reg [2:0] mem_r [0:11];
    integer   i;
    always @(posedge clk or negedge arst_n) begin
        if (!arst_n) begin
            for (i = 0; i < 12; i = i + 1) begin
                mem_r[i] <= `AOS_EXT_SWITCH_FUNCTION_SELECT_RST;
            end
            rd_data <= `AOS_EXT_SWITCH_FUNCTION_SELECT_RST;
        end else begin
            if (wr_en && wr_addr < `AOS_NUM_ESW) begin
                mem_r[wr_addr] <= wr_data;
            end
            if (rd_addr < `AOS_NUM_ESW) begin
                rd_data <= mem_r[rd_addr];
            end else begin
                rd_data <= `AOS_EXT_SWITCH_FUNCTION_SELECT_RST;
            end
        end
    end
endmodule
`default_nettype wire

//--- src/aos_top.v
// Output routing, sense input role and second battery relay control.
// How it works
// [RQ1] Series and shunt regulation run independently.
// [RQ2] Shunt function routes to load or relay.
// [RQ3] One selection per switch block, A to C; the code keeps 12 blocks, A to L.
// [RQ4] Selections 0/1 follow charge demand.
// [RQ5] Selections 2/3 follow load disconnect.
// [RQ6] Selections 4/5 follow low battery alarm.
// [RQ7] Selections 6/7 follow the event.
// [RQ8] Sense role 0 measures main battery.
// [RQ9] Sense role 1 measures second battery.
// [RQ10] Sense role 2 feeds the event input.
// [RQ11] Sense role 3 forces equalise on contact.
// [RQ12] Charge second battery in float when low.
// [RQ13] Function 6 drives terminals from that request.
// [RQ14] Drop back when main falls below float minus hysteresis.
// [RQ15] Relay cycles at most once per 30 seconds.
// [RQ16] Selections change only under program 4.
// [RQ17] Load PWM at 58 Hz only with shunt 10.
// [RQ18] Send a switch command on each block change.
`timescale 1ns/100ps
`default_nettype none
`include "aos_map.vh"
module aos_top #(
    parameter [31:0] RELAY_GAP_CYC = `AOS_RELAY_GAP_CYC,
    parameter [20:0] PWM_PERIOD    = `AOS_PWM_PERIOD
) (
    input  wire        REF_CLK,
    input  wire        ARST_N,
    input  wire [3:0]  ADDR,
    input  wire [15:0] WDATA,
    input  wire        WR,
    input  wire        RD,
    output reg  [15:0] RDATA,
    input  wire [2:0]  PROG_SEL,
    input  wire [11:0] SENSE_MV,
    input  wire [11:0] MAIN_BAT_MV,
    input  wire        MAIN_IN_FLOAT,
    input  wire        CHARGE_WANTED,
    input  wire        LOAD_DISCONNECT,
    input  wire        GEN_RUN,
    input  wire        ALARM_LOW,
    input  wire        EVENT_ACTIVE,
    input  wire        SHUNT_REGULATE,
    input  wire        SERIES_REGULATE,
    input  wire [7:0]  SHUNT_DUTY,
    input  wire        SENSE_CONTACT,
    output reg         SOLAR_INPUT_TERMINAL_ON,
    output reg         LOAD_TERMINAL_ON,
    output reg         RELAY_OUTPUT_ON,
    output reg  [11:0] MAIN_BAT_SENSED_MV,
    output reg  [11:0] SECOND_BAT_MV,
    output reg  [11:0] EXTERNAL_VOLTAGE_EVENT_INPUT,
    output reg         EXTERNAL_VOLTAGE_EVENT_INPUT_SWITCH_EVENT,
    output reg         FORCE_EQUALISE,
    output reg         ESW_CMD_VALID,
    output reg  [3:0]  ESW_CMD_BLOCK,
    output reg         ESW_CMD_ON
);
    reg  [3:0]  load_terminal_function_select_r;
    reg  [3:0]  relay_output_function_select_r;
    reg  [1:0]  sense_input_role_select_r;
    reg  [1:0]  pwm_select_r;
    reg  [11:0] second_battery_setpoint_r;
    reg  [11:0] float_voltage_setpoint_r;
    reg  [11:0] switching_hysteresis_r;
    reg  [3:0]  esw_cursor_r;
    reg         b2_charge_r;
    reg  [31:0] gap_cnt_r;
    reg  [20:0] pwm_cnt_r;
    reg  [11:0] esw_state_r;
    reg  [3:0]  scan_r;
    reg  [3:0]  scan_d_r;
    reg         tx_state_r;
    wire [2:0]  esw_sel;
    wire        edit_ok;
    wire        esw_now;
    wire        b2_req;
    wire        b2_drop;
    wire [12:0] drop_lvl;
    wire        shunt_pwm;
    wire        load_fn;
    wire        relay_fn;

    // Maps a terminal function code to its on or off level.
    function term_level;
        input [3:0] fn;
        input       disc;
        input       gen;
        input       evt;
        input       b2;
        input       alm;
        input       sh;
        begin
            case (fn)
                `AOS_FN_DISC_ON:   term_level = disc;
                `AOS_FN_DISC_OFF:  term_level = !disc;
                `AOS_FN_GEN_ON:    term_level = gen;
                `AOS_FN_GEN_OFF:   term_level = !gen;
                `AOS_FN_EVT_ON:    term_level = evt;
                `AOS_FN_EVT_OFF:   term_level = !evt;
                `AOS_FN_B2_ON:     term_level = b2;
                `AOS_FN_B2_OFF:    term_level = !b2;
                `AOS_FN_ALM_ON:    term_level = alm;
                `AOS_FN_ALM_OFF:   term_level = !alm;
                `AOS_FN_SHUNT_ON:  term_level = sh;
                `AOS_FN_SHUNT_OFF: term_level = !sh;
                default:           term_level = 1'b0;
            endcase
        end
    endfunction

    assign edit_ok = (PROG_SEL == `AOS_PROG_EDIT); // RQ16

    aos_sel_mem u_sel (
        .clk     (REF_CLK),
        .arst_n  (ARST_N),
        .wr_en   (WR && ADDR == `AOS_ADDR_ESW && edit_ok), // RQ16
        .wr_addr (esw_cursor_r),
        .wr_data (WDATA[2:0]),
        .rd_addr (scan_r),
        .rd_data (esw_sel)
    );

    // Register writes; the switch cursor steps A..L (0..11) and wraps to A.
    always @(posedge REF_CLK or negedge ARST_N) begin
        if (!ARST_N) begin
            load_terminal_function_select_r <= `AOS_LOAD_TERMINAL_FUNCTION_SELECT_RST;
            relay_output_function_select_r  <= `AOS_RELAY_OUTPUT_FUNCTION_SELECT_RST;
            sense_input_role_select_r       <= `AOS_SENSE_MAIN;
            pwm_select_r                    <= 2'h0;
            second_battery_setpoint_r       <= 12'h000;
            float_voltage_setpoint_r        <= 12'h000;
            switching_hysteresis_r          <= 12'h000;
            esw_cursor_r                    <= 4'h0;
        end else if (WR) begin
            if (ADDR == `AOS_ADDR_TERM && edit_ok) begin // RQ16
                load_terminal_function_select_r <= WDATA[3:0];
                relay_output_function_select_r  <= WDATA[7:4];
                pwm_select_r                    <= WDATA[9:8];
            end else if (ADDR == `AOS_ADDR_ESW && edit_ok) begin
                if (esw_cursor_r == `AOS_NUM_ESW - 4'h1) begin // RQ3
                    esw_cursor_r <= 4'h0;
                end else begin
                    esw_cursor_r <= esw_cursor_r + 4'h1;
                end
            end else if (ADDR == `AOS_ADDR_SENSE && edit_ok) begin
                sense_input_role_select_r <= WDATA[1:0];
            end else if (ADDR == `AOS_ADDR_BAT2SP) begin
                second_battery_setpoint_r <= WDATA[11:0];
            end else if (ADDR == `AOS_ADDR_FLOAT) begin
                float_voltage_setpoint_r <= WDATA[11:0];
            end else if (ADDR == `AOS_ADDR_SWITCHING_HYSTERESIS) begin
                switching_hysteresis_r <= WDATA[11:0];
            end
        end
    end

    always @(posedge REF_CLK or negedge ARST_N) begin
        if (!ARST_N) begin
            RDATA <= 16'h0000;
        end else if (RD) begin
            if (ADDR == `AOS_ADDR_TERM) begin
                RDATA <= {6'h00, pwm_select_r,
                          relay_output_function_select_r,
                          load_terminal_function_select_r};
            end else if (ADDR == `AOS_ADDR_ESW) begin
                RDATA <= {12'h000, esw_cursor_r};
            end else if (ADDR == `AOS_ADDR_SENSE) begin
                RDATA <= {14'h0000, sense_input_role_select_r};
            end else if (ADDR == `AOS_ADDR_BAT2SP) begin
                RDATA <= {4'h0, second_battery_setpoint_r};
            end else if (ADDR == `AOS_ADDR_FLOAT) begin
                RDATA <= {4'h0, float_voltage_setpoint_r};
            end else if (ADDR == `AOS_ADDR_SWITCHING_HYSTERESIS) begin
                RDATA <= {4'h0, switching_hysteresis_r};
            end else if (ADDR == `AOS_ADDR_STATUS) begin
                RDATA <= {11'h000, FORCE_EQUALISE, b2_charge_r,
                          RELAY_OUTPUT_ON, LOAD_TERMINAL_ON,
                          SOLAR_INPUT_TERMINAL_ON};
            end else if (ADDR == `AOS_ADDR_ESWOUT) begin
                RDATA <= {4'h0, esw_state_r};
            end else begin
                RDATA <= 16'h0000;
            end
        end
    end

    // Sense terminal role steering.
    always @(posedge REF_CLK or negedge ARST_N) begin
        if (!ARST_N) begin
            MAIN_BAT_SENSED_MV           <= 12'h000;
            SECOND_BAT_MV                <= 12'h000;
            EXTERNAL_VOLTAGE_EVENT_INPUT <= 12'h000;
            EXTERNAL_VOLTAGE_EVENT_INPUT_SWITCH_EVENT            <= 1'b0;
            FORCE_EQUALISE               <= 1'b0;
        end else begin
            MAIN_BAT_SENSED_MV <=
                (sense_input_role_select_r == `AOS_SENSE_MAIN) ?
                SENSE_MV : MAIN_BAT_MV; // RQ8
            SECOND_BAT_MV <=
                (sense_input_role_select_r == `AOS_SENSE_SECOND_BATTERY_SETPOINT) ?
                SENSE_MV : 12'h000; // RQ9
            EXTERNAL_VOLTAGE_EVENT_INPUT <=
                (sense_input_role_select_r == `AOS_SENSE_EXTERNAL_VOLTAGE_EVENT_INPUT) ?
                SENSE_MV : 12'h000; // RQ10
            EXTERNAL_VOLTAGE_EVENT_INPUT_SWITCH_EVENT <= SENSE_CONTACT &&
                (sense_input_role_select_r == `AOS_SENSE_EXTERNAL_VOLTAGE_EVENT_INPUT); // RQ10
            FORCE_EQUALISE <= SENSE_CONTACT &&
                (sense_input_role_select_r == `AOS_SENSE_EQ); // RQ11
        end
    end

    // The hold-off counter keeps a mechanical changeover relay from
    // chattering when the main battery sits near its float level.
    assign b2_req = MAIN_IN_FLOAT &&
        (sense_input_role_select_r == `AOS_SENSE_SECOND_BATTERY_SETPOINT) &&
        (SENSE_MV < second_battery_setpoint_r); // RQ12
    assign drop_lvl = {1'b0, float_voltage_setpoint_r} -
                      {1'b0, switching_hysteresis_r};
    assign b2_drop = drop_lvl[12] ? 1'b0 :
        ({1'b0, MAIN_BAT_MV} < drop_lvl); // RQ14

    always @(posedge REF_CLK or negedge ARST_N) begin
        if (!ARST_N) begin
            b2_charge_r <= 1'b0;
            gap_cnt_r   <= 32'h00000000;
        end else begin
            if (gap_cnt_r != 32'h00000000) begin
                gap_cnt_r <= gap_cnt_r - 32'h00000001; // RQ15
            end else if (b2_charge_r && (b2_drop || !b2_req)) begin
                b2_charge_r <= 1'b0; // RQ14
                gap_cnt_r   <= RELAY_GAP_CYC; // RQ15
            end else if (!b2_charge_r && b2_req && !b2_drop) begin
                b2_charge_r <= 1'b1; // RQ12
                gap_cnt_r   <= RELAY_GAP_CYC; // RQ15
            end
        end
    end

    // Shunt PWM on the load terminal; inversion of PWM is not allowed.
    always @(posedge REF_CLK or negedge ARST_N) begin
        if (!ARST_N) begin
            pwm_cnt_r <= 21'h000000;
        end else if (pwm_cnt_r >= PWM_PERIOD - 21'h000001) begin
            pwm_cnt_r <= 21'h000000;
        end else begin
            pwm_cnt_r <= pwm_cnt_r + 21'h000001;
        end
    end
    assign shunt_pwm = pwm_cnt_r[20:13] < SHUNT_DUTY;
    assign load_fn = term_level(load_terminal_function_select_r,
        LOAD_DISCONNECT, GEN_RUN, EVENT_ACTIVE, b2_charge_r,
        ALARM_LOW, SHUNT_REGULATE); // RQ2 RQ13
    assign relay_fn = term_level(relay_output_function_select_r,
        LOAD_DISCONNECT, GEN_RUN, EVENT_ACTIVE, b2_charge_r,
        ALARM_LOW, SHUNT_REGULATE); // RQ2 RQ13

    always @(posedge REF_CLK or negedge ARST_N) begin
        if (!ARST_N) begin
            SOLAR_INPUT_TERMINAL_ON <= 1'b0;
            LOAD_TERMINAL_ON        <= 1'b0;
            RELAY_OUTPUT_ON         <= 1'b0;
        end else begin
            SOLAR_INPUT_TERMINAL_ON <= SERIES_REGULATE; // RQ1
            if (pwm_select_r[1] && load_terminal_function_select_r ==
                `AOS_FN_SHUNT_ON) begin
                LOAD_TERMINAL_ON <= SHUNT_REGULATE && shunt_pwm; // RQ17
            end else begin
                LOAD_TERMINAL_ON <= load_fn; // RQ1
            end
            RELAY_OUTPUT_ON <= relay_fn;
        end
    end

    // Scan the switch blocks in turn; memory read lags one cycle.
    assign esw_now =
        (esw_sel[2:1] == 2'h0) ? (CHARGE_WANTED ^ esw_sel[0]) : // RQ4
        (esw_sel[2:1] == 2'h1) ? (LOAD_DISCONNECT ^ esw_sel[0]) : // RQ5
        (esw_sel[2:1] == 2'h2) ? (ALARM_LOW ^ esw_sel[0]) : // RQ6
        (EVENT_ACTIVE ^ esw_sel[0]); // RQ7

    always @(posedge REF_CLK or negedge ARST_N) begin
        if (!ARST_N) begin
            scan_r        <= 4'h0;
            scan_d_r      <= 4'h0;
            tx_state_r    <= 1'b0;
            esw_state_r   <= 12'h000;
            ESW_CMD_VALID <= 1'b0;
            ESW_CMD_BLOCK <= 4'h0;
            ESW_CMD_ON    <= 1'b0;
        end else begin
            ESW_CMD_VALID <= 1'b0;
            scan_d_r <= scan_r;
            scan_r <= (scan_r == `AOS_NUM_ESW - 4'h1) ? 4'h0 :
                      scan_r + 4'h1;
            tx_state_r <= 1'b1;
            if (tx_state_r && esw_state_r[scan_d_r] != esw_now) begin
                esw_state_r[scan_d_r] <= esw_now;
                ESW_CMD_VALID <= 1'b1; // RQ18
                ESW_CMD_BLOCK <= scan_d_r;
                ESW_CMD_ON    <= esw_now;
            end
        end
    end
endmodule
`default_nettype wire

//--- dv/aos_checker.sv
// Port-level assertions for the output and sense selection block.
`timescale 1ns/100ps
`default_nettype none
module aos_checker #(
    parameter [31:0] RELAY_GAP_CYC = 32'd20
) (
    input wire logic        REF_CLK,
    input wire logic        ARST_N,
    input wire logic [3:0]  ADDR,
    input wire logic [15:0] WDATA,
    input wire logic        WR,
    input wire logic [2:0]  PROG_SEL,
    input wire logic [11:0] SENSE_MV,
    input wire logic        SHUNT_REGULATE,
    input wire logic        SERIES_REGULATE,
    input wire logic        SENSE_CONTACT,
    input wire logic        SOLAR_INPUT_TERMINAL_ON,
    input wire logic        LOAD_TERMINAL_ON,
    input wire logic        RELAY_OUTPUT_ON,
    input wire logic [11:0] MAIN_BAT_SENSED_MV,
    input wire logic [11:0] SECOND_BAT_MV,
    input wire logic [11:0] EXTERNAL_VOLTAGE_EVENT_INPUT,
    input wire logic        EXTERNAL_VOLTAGE_EVENT_INPUT_SWITCH_EVENT,
    input wire logic        FORCE_EQUALISE,
    input wire logic        ESW_CMD_VALID,
    input wire logic [3:0]  ESW_CMD_BLOCK
);
    // Shadow copies of the locked settings, so checks can key on them.
    logic [9:0]  term_r;
    logic [1:0]  role_r;
    logic [31:0] since_r;
    logic        edit;
    assign edit = WR && PROG_SEL == 3'h4;
    always_ff @(posedge REF_CLK or negedge ARST_N) begin
        if (!ARST_N) begin
            term_r  <= 10'h021;
            role_r  <= 2'h0;
            since_r <= '1;
        end else begin
            if (edit && ADDR == 4'h0) term_r <= WDATA[9:0];
            if (edit && ADDR == 4'h2) role_r <= WDATA[1:0];
            // A new terminal function marks the gap as elapsed; it is not a relay cycle.
            if (edit && ADDR == 4'h0) since_r <= '1;
            else if ($changed(LOAD_TERMINAL_ON)) since_r <= '0;
            else if (~&since_r) since_r <= since_r + 32'd1;
        end
    end
    default clocking @(posedge REF_CLK); endclocking
    default disable iff (!ARST_N);
    sequence s_role(logic [1:0] r);
        (role_r == r && $stable(SENSE_MV) && $stable(SENSE_CONTACT))[*3];
    endsequence
    sequence s_shl;
        (term_r[3:0] == 4'hA && !term_r[9] && $stable(SHUNT_REGULATE))[*3];
    endsequence
    sequence s_shr;
        (term_r[7:4] == 4'hB && $stable(SHUNT_REGULATE))[*3];
    endsequence
    property p_solar;
        $past(ARST_N) |-> SOLAR_INPUT_TERMINAL_ON == $past(SERIES_REGULATE);
    endproperty
    property p_blk;
        ESW_CMD_VALID |-> ESW_CMD_BLOCK < 4'hC;
    endproperty
    property p_scan;
        ESW_CMD_VALID ##1 ESW_CMD_VALID
            |-> ESW_CMD_BLOCK != $past(ESW_CMD_BLOCK);
    endproperty
    property p_main;
        s_role(2'h0) |-> MAIN_BAT_SENSED_MV == SENSE_MV;
    endproperty
    property p_second_battery_setpoint;
        s_role(2'h1) |-> SECOND_BAT_MV == SENSE_MV;
    endproperty
    property p_external_voltage_event_input;
        s_role(2'h2) |-> EXTERNAL_VOLTAGE_EVENT_INPUT == SENSE_MV
            && EXTERNAL_VOLTAGE_EVENT_INPUT_SWITCH_EVENT == SENSE_CONTACT;
    endproperty
    property p_equal;
        s_role(2'h3) |-> FORCE_EQUALISE == SENSE_CONTACT;
    endproperty
    property p_shl;
        s_shl |-> LOAD_TERMINAL_ON == SHUNT_REGULATE;
    endproperty
    property p_shr;
        s_shr |-> RELAY_OUTPUT_ON == !SHUNT_REGULATE;
    endproperty
    property p_gap;
        term_r[3:0] == 4'h6 && $changed(LOAD_TERMINAL_ON)
            |-> since_r >= RELAY_GAP_CYC - 32'd1;
    endproperty
    a_solar: assert property (p_solar)
        else $error("solar output does not follow series demand");
    a_blk: assert property (p_blk)
        else $error("switch command names a missing block");
    a_scan: assert property (p_scan)
        else $error("same block commanded twice in a row");
    a_main: assert property (p_main)
        else $error("main battery reading not taken from sense");
    a_second_battery_setpoint: assert property (p_second_battery_setpoint)
        else $error("second battery reading not taken from sense");
    a_external_voltage_event_input: assert property (p_external_voltage_event_input)
        else $error("event input not taken from sense");
    a_equal: assert property (p_equal)
        else $error("equalise force does not follow contact");
    a_shl: assert property (p_shl)
        else $error("load terminal does not follow shunt");
    a_shr: assert property (p_shr)
        else $error("relay does not follow inverted shunt");
    a_gap: assert property (p_gap)
        else $error("changeover relay cycled too soon");
endmodule
bind aos_top aos_checker #(.RELAY_GAP_CYC(RELAY_GAP_CYC)) u_aos_checker (
    .REF_CLK, .ARST_N, .ADDR, .WDATA, .WR, .PROG_SEL, .SENSE_MV,
    .SHUNT_REGULATE, .SERIES_REGULATE, .SENSE_CONTACT,
    .SOLAR_INPUT_TERMINAL_ON, .LOAD_TERMINAL_ON, .RELAY_OUTPUT_ON,
    .MAIN_BAT_SENSED_MV, .SECOND_BAT_MV, .EXTERNAL_VOLTAGE_EVENT_INPUT,
    .EXTERNAL_VOLTAGE_EVENT_INPUT_SWITCH_EVENT, .FORCE_EQUALISE, .ESW_CMD_VALID, .ESW_CMD_BLOCK
);
`default_nettype wire

//--- dv/aos_esw_model.sv
// Model of the external switch blocks on the serial bus.
`timescale 1ns/100ps
`default_nettype none
module aos_esw_model (
    input  wire logic        clk,
    input  wire logic        arst_n,
    input  wire logic        cmd_valid,
    input  wire logic [3:0]  cmd_block,
    input  wire logic        cmd_on,
    output var  logic [11:0] sw_state
);
    // A block keeps its last command; there is no read-back on the bus.
    always_ff @(posedge clk or negedge arst_n) begin
        if (!arst_n) sw_state <= 12'h000;
        else if (cmd_valid && cmd_block < 4'hC) sw_state[cmd_block] <= cmd_on;
    end
endmodule
`default_nettype wire

//--- dv/aos_top_test.sv
// Self-checking bench for the output and sense selection block.
`timescale 1ns/100ps
`default_nettype none
module aos_top_test;
    logic        REF_CLK = 1'b0, ARST_N = 1'b0, WR = 1'b0, RD = 1'b0;
    logic        MAIN_IN_FLOAT = 1'b0, CHARGE_WANTED = 1'b0, GEN_RUN = 1'b0;
    logic        LOAD_DISCONNECT = 1'b0, ALARM_LOW = 1'b0, EVENT_ACTIVE = 1'b0;
    logic        SHUNT_REGULATE = 1'b0, SERIES_REGULATE = 1'b0;
    logic        SENSE_CONTACT = 1'b0;
    logic [3:0]  ADDR = 4'h0;
    logic [15:0] WDATA = 16'h0000;
    logic [2:0]  PROG_SEL = 3'h0;
    logic [7:0]  SHUNT_DUTY = 8'h80;
    logic [11:0] SENSE_MV = 12'h000, MAIN_BAT_MV = 12'h000;
    logic        SOLAR_INPUT_TERMINAL_ON, LOAD_TERMINAL_ON, RELAY_OUTPUT_ON;
    logic        EXTERNAL_VOLTAGE_EVENT_INPUT_SWITCH_EVENT, FORCE_EQUALISE, ESW_CMD_VALID, ESW_CMD_ON;
    logic [3:0]  ESW_CMD_BLOCK;
    logic [15:0] RDATA, rv;
    logic [11:0] MAIN_BAT_SENSED_MV, SECOND_BAT_MV, sw_state;
    logic [11:0] EXTERNAL_VOLTAGE_EVENT_INPUT;
    int          bad_count = 0, n_compared = 0, cycles = 0;
    aos_top #(.RELAY_GAP_CYC(32'd20)) u_aos_top (
        .REF_CLK, .ARST_N, .ADDR, .WDATA, .WR, .RD, .RDATA, .PROG_SEL,
        .SENSE_MV, .MAIN_BAT_MV, .MAIN_IN_FLOAT, .CHARGE_WANTED,
        .LOAD_DISCONNECT, .GEN_RUN, .ALARM_LOW, .EVENT_ACTIVE,
        .SHUNT_REGULATE, .SERIES_REGULATE, .SHUNT_DUTY, .SENSE_CONTACT,
        .SOLAR_INPUT_TERMINAL_ON, .LOAD_TERMINAL_ON, .RELAY_OUTPUT_ON,
        .MAIN_BAT_SENSED_MV, .SECOND_BAT_MV, .EXTERNAL_VOLTAGE_EVENT_INPUT,
        .EXTERNAL_VOLTAGE_EVENT_INPUT_SWITCH_EVENT, .FORCE_EQUALISE, .ESW_CMD_VALID, .ESW_CMD_BLOCK,
        .ESW_CMD_ON
    );
    aos_esw_model u_aos_esw_model (
        .clk(REF_CLK), .arst_n(ARST_N), .cmd_valid(ESW_CMD_VALID),
        .cmd_block(ESW_CMD_BLOCK), .cmd_on(ESW_CMD_ON), .sw_state(sw_state)
    );
    initial begin
        forever #5 REF_CLK = ~REF_CLK;
    end
    task automatic end_of_test();
        $display("Compared %0d, mismatched %0d", n_compared, bad_count);
        if (bad_count == 0 && n_compared > 0) $display("NO MISMATCHES");
        else $display("MISMATCHES SEEN");
        $finish;
    endtask
    always @(posedge REF_CLK) begin
        cycles++;
        if (cycles == 20000) begin
            bad_count++;
            end_of_test();
        end
    end
    task automatic chk(input logic [15:0] seen, input logic [15:0] exp);
        n_compared++;
        if (seen !== exp) begin
            bad_count++;
            $display("Error at %0t: saw %h expected %h", $time, seen, exp);
        end
    endtask
    task automatic chkb(input logic seen, input logic exp);
        chk({15'h0, seen}, {15'h0, exp});
    endtask
    task automatic cyc(input int n);
        repeat (n) @(posedge REF_CLK);
        #1;
    endtask
    task automatic wr(input logic [3:0] a, input logic [15:0] d);
        @(posedge REF_CLK);
        ADDR <= a;
        WDATA <= d;
        WR <= 1'b1;
        @(posedge REF_CLK);
        WR <= 1'b0;
    endtask
    task automatic rd(input logic [3:0] a);
        @(posedge REF_CLK);
        ADDR <= a;
        RD <= 1'b1;
        @(posedge REF_CLK);
        RD <= 1'b0;
        #1 rv = RDATA;
    endtask
    function automatic logic [15:0] esw_exp(input logic [3:0] p);
        logic [15:0] e;
        e = 16'h0000;
        for (int i = 0; i < 12; i++) e[i] = p[(i % 8) / 2] ^ i[0];
        return e;
    endfunction
    task automatic t_regs();
        rd(4'h0);
        chk(rv, 16'h0021);
        rd(4'hF);
        chk(rv, 16'h0000);
        wr(4'h0, 16'h00A7);
        wr(4'h1, 16'h0007);
        wr(4'h2, 16'h0003);
        rd(4'h0);
        chk(rv, 16'h0021);
        rd(4'h1);
        chk(rv, 16'h0000);
        rd(4'h2);
        chk(rv, 16'h0000);
    endtask
    task automatic t_esw();
        @(posedge REF_CLK);
        PROG_SEL <= 3'h4;
        for (int i = 0; i < 12; i++) wr(4'h1, 16'(i % 8));
        rd(4'h1);
        chk(rv, 16'h0000);
        for (int p = 0; p < 16; p++) begin
            @(posedge REF_CLK);
            CHARGE_WANTED <= p[0];
            LOAD_DISCONNECT <= p[1];
            ALARM_LOW <= p[2];
            EVENT_ACTIVE <= p[3];
            cyc(30);
            rd(4'h7);
            chk(rv, esw_exp(p[3:0]));
            chk({4'h0, sw_state}, esw_exp(p[3:0]));
        end
    endtask
    task automatic t_sense();
        @(posedge REF_CLK);
        SENSE_CONTACT <= 1'b1;
        for (int r = 0; r < 4; r++) begin
            wr(4'h2, 16'(r));
            SENSE_MV <= 12'h5A0 + 12'(r);
            cyc(4);
            case (r)
                0: chk({4'h0, MAIN_BAT_SENSED_MV}, 16'h05A0);
                1: chk({4'h0, SECOND_BAT_MV}, 16'h05A1);
                2: chk({3'h0, EXTERNAL_VOLTAGE_EVENT_INPUT_SWITCH_EVENT, EXTERNAL_VOLTAGE_EVENT_INPUT},
                       16'h15A2);
                default: chkb(FORCE_EQUALISE, 1'b1);
            endcase
        end
        @(posedge REF_CLK);
        SENSE_CONTACT <= 1'b0;
        cyc(4);
        chkb(FORCE_EQUALISE, 1'b0);
    endtask
    task automatic t_shunt();
        wr(4'h0, 16'h00BA);
        SERIES_REGULATE <= 1'b1;
        for (int s = 1; s >= 0; s--) begin
            @(posedge REF_CLK);
            SHUNT_REGULATE <= s[0];
            cyc(4);
            chkb(LOAD_TERMINAL_ON, s[0]);
            chkb(RELAY_OUTPUT_ON, !s[0]);
            chkb(SOLAR_INPUT_TERMINAL_ON, 1'b1);
        end
        // Load PWM on; the counter stays in its first half in this run.
        wr(4'h0, 16'h02BA);
        SHUNT_REGULATE <= 1'b1;
        SHUNT_DUTY <= 8'h00;
        cyc(4);
        chkb(LOAD_TERMINAL_ON, 1'b0);
        @(posedge REF_CLK);
        SHUNT_DUTY <= 8'h80;
        cyc(4);
        chkb(LOAD_TERMINAL_ON, 1'b1);
        chkb(RELAY_OUTPUT_ON, 1'b0);
        @(posedge REF_CLK);
        SHUNT_REGULATE <= 1'b0;
    endtask
    task automatic t_second_battery_setpoint();
        @(posedge REF_CLK);
        SENSE_MV <= 12'h700;
        MAIN_BAT_MV <= 12'h650;
        wr(4'h3, 16'h0800);
        wr(4'h4, 16'h0600);
        wr(4'h5, 16'h0040);
        wr(4'h2, 16'h0001);
        wr(4'h0, 16'h0066);
        cyc(5);
        chkb(LOAD_TERMINAL_ON, 1'b0);
        @(posedge REF_CLK);
        MAIN_IN_FLOAT <= 1'b1;
        cyc(5);
        chkb(LOAD_TERMINAL_ON, 1'b1);
        chkb(RELAY_OUTPUT_ON, 1'b1);
        rd(4'h6);
        chk(rv, 16'h000F);
        @(posedge REF_CLK);
        MAIN_BAT_MV <= 12'h5A0;
        cyc(3);
        chkb(LOAD_TERMINAL_ON, 1'b1);
        cyc(25);
        chkb(LOAD_TERMINAL_ON, 1'b0);
        rd(4'h6);
        chk(rv, 16'h0001);
    endtask
    initial begin
        repeat (3) @(posedge REF_CLK);
        ARST_N <= 1'b1;
        t_regs();
        t_esw();
        t_sense();
        t_shunt();
        t_second_battery_setpoint();
        end_of_test();
    end
endmodule
`default_nettype wire
